// file: rtl/ctar_params.svh
`ifndef CTAR_PARAMS_SVH
`define CTAR_PARAMS_SVH
// Register offsets on the serial control bus
`define CTAR_ADDR_SYNC_POL 8'h03
`define CTAR_ADDR_CLAMP_TIME 8'h07
`define CTAR_ADDR_COARSE_CTRL 8'h09
`define CTAR_ADDR_TIMING 8'h0a
`define CTAR_ADDR_REF_ADJ 8'h0b
`define CTAR_ADDR_AUX_BASE 8'h10
// Field positions
`define CTAR_POS_SYNC_POL 5
`define CTAR_POS_ON_TIME 3
`define CTAR_POS_SYNC_SEL 6
`define CTAR_POS_OSC_EN 0
`define CTAR_POS_BIAS_DBL 1
`define CTAR_POS_DUTY_EQ 3
`define CTAR_POS_CLK_DLY 5
`define CTAR_POS_REF_TRIM 4
// Reset values (none documented; chosen safe)
`define CTAR_RST_TIMING 8'h01
`define CTAR_RST_REF_ADJ 8'h01
`define CTAR_RST_ZERO 8'h00
`endif

// file: rtl/ctar_pkg.sv
package ctar_pkg;
  typedef logic [7:0] ctar_byte_t;
  typedef enum logic [1:0] {CTAR_IDLE, CTAR_ARMED, CTAR_ON} ctar_clamp_e;
endpackage

// file: rtl/ctar_clamp_if.sv
interface ctar_clamp_if;
  logic fire;
  logic [2:0] on_time;
  logic active;
  modport ctrl(output fire, output on_time, input active);
  modport timer(input fire, input on_time, output active);
endinterface

// file: rtl/ctar_clamp_timer.sv
module ctar_clamp_timer (
  input wire logic clk_in,
  input wire logic rstn_in,
  ctar_clamp_if.timer ctl
);
  typedef struct packed {
    logic [2:0] cnt;
    logic act;
  } ctar_tmr_s;
  ctar_tmr_s cur_ff;
  ctar_tmr_s nxt_st;

  // Down-counter holds clamp on until count expires
  always_comb begin
    nxt_st = cur_ff;
    if (ctl.fire && ctl.on_time != 3'h0) begin
      nxt_st.cnt = ctl.on_time;
      nxt_st.act = 1'b1;
    end else if (cur_ff.act) begin
      if (cur_ff.cnt == 3'h1) begin
        nxt_st.act = 1'b0;
        nxt_st.cnt = 3'h0;
      end else begin
        nxt_st.cnt = cur_ff.cnt - 3'h1;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  assign ctl.active = cur_ff.act;
endmodule

// file: rtl/ctar_regs.sv
`include "ctar_params.svh"
// Overview of operation
// - Coarse on bit fires clamp for on-time
// - Direction bit drives clamp while enabled
// - Oscillator-enable zero disables crystal oscillator
// - Bias-double bit doubles analog bias currents
// - Duty equalizer affects ADC clock only
// - Clock-delay field sets core clock delay
// - Three-bit ADC reference trim field
// - Eight read-only aux registers from 10H
// - Aux register n shows aux input n
// - Sync-select on: clamps fire on sync
// - Sync edge-detected, polarity bit selects edge
// - Sync-select off: clamps fire on bit
// - On bits edge-detected; clear before retrigger
// - Coarse on-time sets clamp cycle count
// - Polarity zero: low pulse is sync
module ctar_regs #(
  parameter int NUM_CLAMPS = 3,
  parameter int NUM_AUX = 8
) (
  input wire logic SYS_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic WR_EN_IN,
  input wire logic RD_EN_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  output logic [7:0] RDATA_OUT,
  input wire logic SYNC_IN,
  input wire logic AUX_VALID_IN,
  input wire logic [2:0] AUX_CHAN_IN,
  input wire logic [7:0] AUX_DATA_IN,
  output logic [NUM_CLAMPS-1:0] CLAMP_ON_OUT,
  output logic [NUM_CLAMPS-1:0] CLAMP_UP_OUT,
  output logic OSC_ENABLE_OUT,
  output logic BIAS_DOUBLE_OUT,
  output logic DUTY_EQ_ENABLE_OUT,
  output logic [1:0] CORE_CLK_DELAY_OUT,
  output logic [2:0] ADC_REF_TRIM_OUT
);
  // Whole register file and edge history in one registered struct
  typedef struct packed {
    ctar_pkg::ctar_byte_t sync_pol_reg;
    ctar_pkg::ctar_byte_t clamp_time_reg;
    ctar_pkg::ctar_byte_t coarse_clamp_control;
    ctar_pkg::ctar_byte_t timing_config;
    ctar_pkg::ctar_byte_t adc_reference_adjust;
    logic [NUM_AUX-1:0][7:0] aux_monitor_result;
    logic [NUM_CLAMPS-1:0] on_prev;
    logic sync_prev;
    ctar_pkg::ctar_byte_t rdata;
    logic [NUM_CLAMPS-1:0] clamp_up;
    logic [NUM_CLAMPS-1:0] clamp_on;
    logic [NUM_CLAMPS-1:0] armed;
  } ctar_state_s;

  ctar_state_s cur_ff;
  ctar_state_s nxt_st;
  // Per-clamp wiring between the bank and its timers
  logic [NUM_CLAMPS-1:0] fire;
  logic [NUM_CLAMPS-1:0] active;
  logic [NUM_CLAMPS-1:0] on_bit;
  logic [NUM_CLAMPS-1:0] dir_bit;
  logic sync_sel;
  logic sync_pol;
  logic sync_lvl;
  logic sync_edge;

  // Address match used by write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    return a == ref_a;
  endfunction

  // Offset falls inside the read-only aux window
  function automatic logic aux_hit(input logic [7:0] a);
    return a >= `CTAR_ADDR_AUX_BASE && 32'(a - `CTAR_ADDR_AUX_BASE) < NUM_AUX;
  endfunction

  // Clamp k control pair sits at bits 2k (direction) and 2k+1 (on)
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CLAMPS; gi++) begin : g_clamp
      ctar_clamp_if cif();
      assign on_bit[gi] = cur_ff.coarse_clamp_control[2*gi+1];
      assign dir_bit[gi] = cur_ff.coarse_clamp_control[2*gi];
      assign cif.fire = fire[gi];
      assign cif.on_time = cur_ff.clamp_time_reg[`CTAR_POS_ON_TIME +: 3];
      assign active[gi] = cif.active;
      ctar_clamp_timer u_tmr (
        .clk_in(SYS_CLK_IN),
        .rstn_in(RSTN_IN),
        .ctl(cif.timer)
      );
    end
  endgenerate

  // Synchronised mode select
  assign sync_sel = cur_ff.clamp_time_reg[`CTAR_POS_SYNC_SEL];
  // Polarity bit picks which level counts as the sync pulse
  assign sync_pol = cur_ff.sync_pol_reg[`CTAR_POS_SYNC_POL];
  assign sync_lvl = sync_pol ? SYNC_IN : ~SYNC_IN;
  // Raw pin history, so rewriting the polarity bit alone never fires a clamp
  assign sync_edge = sync_lvl & (cur_ff.sync_prev ^ sync_pol);

  // Triggering: rising edge of on bit fires now, or arms for next sync
  always_comb begin
    fire = '0;
    for (int k = 0; k < NUM_CLAMPS; k++) begin
      if (sync_sel) begin
        fire[k] = cur_ff.armed[k] & sync_edge;
      end else begin
        fire[k] = on_bit[k] & ~cur_ff.on_prev[k];
      end
    end
  end

  // Next-state: register writes, aux capture, edge history, read data
  always_comb begin
    nxt_st = cur_ff;
    nxt_st.sync_prev = SYNC_IN; // Raw pin level, polarity applied on use
    nxt_st.on_prev = on_bit;

    // One-shot arming per clamp for synchronised mode
    for (int k = 0; k < NUM_CLAMPS; k++) begin
      if (!sync_sel || fire[k]) begin
        nxt_st.armed[k] = 1'b0;
      end
      // Arming on the bit edge beats consumption by a same-cycle sync
      if (sync_sel && on_bit[k] && !cur_ff.on_prev[k]) begin
        nxt_st.armed[k] = 1'b1;
      end
    end

    // Clamp pins registered once more so each leaves a flip-flop
    for (int k = 0; k < NUM_CLAMPS; k++) begin
      nxt_st.clamp_on[k] = active[k];
      // Direction means nothing while the clamp is off, so hold it low
      if (active[k]) begin
        nxt_st.clamp_up[k] = dir_bit[k];
      end else begin
        nxt_st.clamp_up[k] = 1'b0;
      end
    end

    // Latest conversion per channel; out-of-range channels are dropped
    if (AUX_VALID_IN && 32'(AUX_CHAN_IN) < NUM_AUX) begin
      nxt_st.aux_monitor_result[AUX_CHAN_IN] = AUX_DATA_IN;
    end

    // Reserved bits stored as written; host is responsible for them
    if (WR_EN_IN) begin
      if (hit(ADDR_IN, `CTAR_ADDR_SYNC_POL)) begin
        nxt_st.sync_pol_reg = WDATA_IN;
      end
      if (hit(ADDR_IN, `CTAR_ADDR_CLAMP_TIME)) begin
        nxt_st.clamp_time_reg = WDATA_IN;
      end
      if (hit(ADDR_IN, `CTAR_ADDR_COARSE_CTRL)) begin
        nxt_st.coarse_clamp_control = WDATA_IN;
      end
      if (hit(ADDR_IN, `CTAR_ADDR_TIMING)) begin
        nxt_st.timing_config = WDATA_IN;
      end
      if (hit(ADDR_IN, `CTAR_ADDR_REF_ADJ)) begin
        nxt_st.adc_reference_adjust = WDATA_IN;
      end
      // Aux window ignores writes, so results cannot be forged
    end

    // Idle cycles and unmapped offsets read as zero
    nxt_st.rdata = 8'h00;
    if (RD_EN_IN) begin
      if (hit(ADDR_IN, `CTAR_ADDR_SYNC_POL)) begin
        nxt_st.rdata = cur_ff.sync_pol_reg;
      end
      if (hit(ADDR_IN, `CTAR_ADDR_CLAMP_TIME)) begin
        nxt_st.rdata = cur_ff.clamp_time_reg;
      end
      if (hit(ADDR_IN, `CTAR_ADDR_COARSE_CTRL)) begin
        nxt_st.rdata = cur_ff.coarse_clamp_control;
      end
      if (hit(ADDR_IN, `CTAR_ADDR_TIMING)) begin
        nxt_st.rdata = cur_ff.timing_config;
      end
      if (hit(ADDR_IN, `CTAR_ADDR_REF_ADJ)) begin
        nxt_st.rdata = cur_ff.adc_reference_adjust;
      end
      if (aux_hit(ADDR_IN)) begin
        nxt_st.rdata = cur_ff.aux_monitor_result[3'(ADDR_IN - `CTAR_ADDR_AUX_BASE)];
      end
    end
  end

  // Timing and reference registers wake with safe values
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      cur_ff <= '0;
      cur_ff.timing_config <= `CTAR_RST_TIMING;
      cur_ff.adc_reference_adjust <= `CTAR_RST_REF_ADJ;
    end else begin
      cur_ff <= nxt_st;
    end
  end

  // Analog-facing timing controls straight from register bits
  assign OSC_ENABLE_OUT = cur_ff.timing_config[`CTAR_POS_OSC_EN];
  assign BIAS_DOUBLE_OUT = cur_ff.timing_config[`CTAR_POS_BIAS_DBL];
  assign DUTY_EQ_ENABLE_OUT = cur_ff.timing_config[`CTAR_POS_DUTY_EQ];
  assign CORE_CLK_DELAY_OUT = cur_ff.timing_config[`CTAR_POS_CLK_DLY +: 2];

  // Reference trim reaches the analog side unchanged
  assign ADC_REF_TRIM_OUT = cur_ff.adc_reference_adjust[`CTAR_POS_REF_TRIM +: 3];

  // Clamp pins and read data leave their own flip-flops
  assign CLAMP_ON_OUT = cur_ff.clamp_on;
  assign CLAMP_UP_OUT = cur_ff.clamp_up;
  assign RDATA_OUT = cur_ff.rdata;
endmodule

// file: tb/ctar_properties.sv
module ctar_properties #(
  parameter int NUM_CLAMPS = 3
) (
  input wire logic SYS_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic WR_EN_IN,
  input wire logic RD_EN_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic [NUM_CLAMPS-1:0] CLAMP_ON_OUT,
  input wire logic [NUM_CLAMPS-1:0] CLAMP_UP_OUT,
  input wire logic OSC_ENABLE_OUT,
  input wire logic BIAS_DOUBLE_OUT,
  input wire logic DUTY_EQ_ENABLE_OUT,
  input wire logic [1:0] CORE_CLK_DELAY_OUT,
  input wire logic [2:0] ADC_REF_TRIM_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  logic wr_tim;
  logic wr_ref;
  // Write decode for the timing and reference registers
  assign wr_tim = WR_EN_IN && ADDR_IN == 8'h0a;
  assign wr_ref = WR_EN_IN && ADDR_IN == 8'h0b;
  // Each control output copies its field one edge after the write
  a_osc_follows: assert property (wr_tim |=> OSC_ENABLE_OUT == $past(WDATA_IN[0]))
    else $error("oscillator enable mismatch");
  a_bias_follows: assert property (wr_tim |=> BIAS_DOUBLE_OUT == $past(WDATA_IN[1]))
    else $error("bias double mismatch");
  a_duty_follows: assert property (wr_tim |=> DUTY_EQ_ENABLE_OUT == $past(WDATA_IN[3]))
    else $error("duty equalizer mismatch");
  a_delay_follows: assert property (wr_tim |=> CORE_CLK_DELAY_OUT == $past(WDATA_IN[6:5]))
    else $error("clock delay mismatch");
  a_trim_follows: assert property (wr_ref |=> ADC_REF_TRIM_OUT == $past(WDATA_IN[6:4]))
    else $error("reference trim mismatch");
  // Read data and the pin come from the same stored bit
  a_readback_osc: assert property (
    RD_EN_IN && ADDR_IN == 8'h0a && !WR_EN_IN |=> RDATA_OUT[0] == OSC_ENABLE_OUT)
    else $error("timing readback disagrees with pin");
  a_dir_gated: assert property ((CLAMP_UP_OUT & ~CLAMP_ON_OUT) == '0)
    else $error("direction shown while clamp idle");
  a_clamp_bounded: assert property ($rose(CLAMP_ON_OUT[1]) |-> ##[1:7] !CLAMP_ON_OUT[1])
    else $error("clamp stayed on too long");
endmodule
bind ctar_regs ctar_properties #(.NUM_CLAMPS(NUM_CLAMPS)) u_props (.*);

// file: tb/ctar_host.sv
module ctar_host (
  input wire logic clk_in,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {wr_out, rd_out, addr_out, wdata_out} = '0;
  // Reserved bits are always written the way the device expects
  function automatic logic [7:0] legal(logic [7:0] a, logic [7:0] d);
    case (a)
      8'h03, 8'h09: return d & 8'h3f;
      8'h07: return d & 8'h7f;
      8'h0a: return d & 8'h6b;
      8'h0b: return d & 8'h70 | 8'h01;
      default: return d;
    endcase
  endfunction
  // One strobed cycle per transfer, launched and dropped on rising edges
  task automatic xfer(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge clk_in);
    wr_out <= w;
    rd_out <= ~w;
    addr_out <= a;
    wdata_out <= legal(a, d);
    @(posedge clk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b0;
  endtask
endmodule

// file: tb/ctar_regs_tb_top.sv
module ctar_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, rstn = 0, sync = 0, aux_v = 0, rd_seen = 0, wr_en, rd, osc, bias, duty;
  logic [2:0] aux_c = 0, clamp_on, clamp_up, trim;
  logic [7:0] aux_d = 0, rdata, addr, wdata;
  logic [1:0] dly;
  logic [3:0] cnt[3] = '{4'h0, 4'h0, 4'h0};
  logic [3:0] upc[3] = '{4'h0, 4'h0, 4'h0};
  logic [6:0] exp_w;
  logic [7:0] exp_q[$];
  // Pulse notes: clamp index, direction up, width in cycles
  logic [6:0] wid_q[$];
  logic [31:0] seed = 32'hded8f07f;
  int err_total = 0, comparisons = 0;
  always #20 sys_clk = ~sys_clk;
  ctar_host HOST (.clk_in(sys_clk), .wr_out(wr_en), .rd_out(rd), .addr_out(addr),
    .wdata_out(wdata));
  ctar_regs DUT (.SYS_CLK_IN(sys_clk), .RSTN_IN(rstn), .WR_EN_IN(wr_en), .RD_EN_IN(rd),
    .ADDR_IN(addr), .WDATA_IN(wdata), .RDATA_OUT(rdata), .SYNC_IN(sync), .AUX_VALID_IN(aux_v),
    .AUX_CHAN_IN(aux_c), .AUX_DATA_IN(aux_d), .CLAMP_ON_OUT(clamp_on), .CLAMP_UP_OUT(clamp_up),
    .OSC_ENABLE_OUT(osc), .BIAS_DOUBLE_OUT(bias), .DUTY_EQ_ENABLE_OUT(duty),
    .CORE_CLK_DELAY_OUT(dly), .ADC_REF_TRIM_OUT(trim));
  task automatic chk_rd(logic [7:0] e, logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED read data expected %h seen %h", e, s);
    end
  endtask
  task automatic chk_wid(logic [5:0] e, logic [5:0] s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED clamp index and width expected %h seen %h", e, s);
    end
  endtask
  task automatic chk_up(logic [3:0] e, logic [3:0] s);
    comparisons++;
    if (s !== e) begin
      err_total++;
      $display("CHECK FAILED clamp up cycles expected %0d seen %0d", e, s);
    end
  endtask
  // Judged on the falling edge, after rising-edge updates land
  always @(negedge sys_clk) begin
    if (rd_seen) chk_rd(exp_q.size() ? exp_q.pop_front() : 8'hxx, rdata);
    rd_seen = rd;
    for (int k = 0; k < 3; k++) begin
      if (clamp_on[k]) begin
        cnt[k] = cnt[k] + 4'h1;
        upc[k] = upc[k] + 4'(clamp_up[k]);
      end else if (cnt[k] != 4'h0) begin
        exp_w = wid_q.size() ? wid_q.pop_front() : 7'hxx;
        chk_wid({exp_w[6:5], exp_w[3:0]}, {k[1:0], cnt[k]});
        chk_up(exp_w[4] ? exp_w[3:0] : 4'h0, upc[k]);
        cnt[k] = 4'h0;
        upc[k] = 4'h0;
      end
    end
  end
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic rd_chk(logic [7:0] a, logic [7:0] e);
    exp_q.push_back(e);
    HOST.xfer(1'b0, a, 8'h00);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    HOST.xfer(1'b1, a, d);
  endtask
  // Reset, registers, aux results, then direct and synchronised clamps
  initial begin
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    rd_chk(8'h0a, 8'h01);
    rd_chk(8'h0b, 8'h01);
    rd_chk(8'hff, 8'h00);
    repeat (4) begin
      seed = lfsr(seed);
      wr(8'h0a, seed[7:0]);
      rd_chk(8'h0a, seed[7:0] & 8'h6b);
      wr(8'h0b, seed[15:8]);
      rd_chk(8'h0b, seed[15:8] & 8'h70 | 8'h01);
    end
    for (int n = 0; n < 8; n++) begin
      seed = lfsr(seed);
      @(posedge sys_clk);
      aux_v <= 1'b1;
      aux_c <= n[2:0];
      aux_d <= seed[7:0];
      @(posedge sys_clk);
      aux_v <= 1'b0;
      wr(8'h10 + n[7:0], ~seed[7:0]);
      rd_chk(8'h10 + n[7:0], seed[7:0]);
    end
    wr(8'h07, 8'h38);
    wid_q.push_back({2'd1, 1'b0, 4'd7});
    wr(8'h09, 8'h08);
    repeat (12) @(posedge sys_clk);
    wr(8'h09, 8'h08);
    wr(8'h07, 8'h08);
    wr(8'h09, 8'h00);
    wid_q.push_back({2'd1, 1'b1, 4'd1});
    wr(8'h09, 8'h0c);
    wr(8'h07, 8'h68);
    for (int p = 0; p < 2; p++) begin
      sync <= ~p[0];
      wr(8'h03, {2'b00, p[0], 5'h00});
      wr(8'h09, 8'h00);
      wr(8'h09, 8'h08);
      repeat (6) @(posedge sys_clk);
      wid_q.push_back({2'd1, 1'b0, 4'd5});
      sync <= p[0];
      repeat (10) @(posedge sys_clk);
    end
    // All three clamps at once, only clamp 0 driving up
    wr(8'h07, 8'h10);
    wr(8'h09, 8'h00);
    wid_q.push_back({2'd0, 1'b1, 4'd2});
    wid_q.push_back({2'd1, 1'b0, 4'd2});
    wid_q.push_back({2'd2, 1'b0, 4'd2});
    wr(8'h09, 8'h2b);
    repeat (8) @(posedge sys_clk);
    results();
  end
  // Watchdog well beyond the roughly 180 cycles the run needs
  initial begin
    #200us;
    err_total++;
    results();
  end
  task automatic results();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
endmodule
